// *** src/hscap_top.sv ***
// Strap capture, shared status pin reuse and port power switch control for the hub.
`timescale 1ns/1ps
// Notes on behaviour
// - Low on port 4 over-current input means over-current; high means none.
// - Serial-mode strap at reset release: 1 selects I2C, 0 selects SMBus.
// - I2C mode drives serial clock to EEPROM; SMBus mode takes host clock.
// - Serial data pin talks to EEPROM in I2C mode, host in SMBus mode.
// - When enabled, serial-mode pin outputs upstream SuperSpeed suspend status.
// - Power-management strap 0 enables switching and over-current inputs; 1 disables.
// - With switching supported, four outputs control downstream port power.
// - In SMBus mode slave address bit 1 comes from power-management strap.
// - When enabled, power-management pin outputs upstream SuperSpeed connection status.
// - Battery charging needs power switching left enabled.
// - Polarity strap sets power control level: 0 active low, 1 active high.
// - In per-port mode each control output follows its port's power request under chosen polarity.
// - Ganged strap with switching on: 0 per-port, 1 ganged control.
module hscap_top (
  input  wire logic       clk_sys,
  input  wire logic       rstn,
  input  wire logic       serial_mode_select_strap_i,
  output logic            serial_mode_select_strap_o,
  output logic            serial_mode_select_strap_oe,
  input  wire logic       power_mgmt_disable_strap_i,
  output logic            power_mgmt_disable_strap_o,
  output logic            power_mgmt_disable_strap_oe,
  input  wire logic       switch_polarity_strap,
  input  wire logic       ganged_strap,
  input  wire logic       port4_overcurrent_n,
  input  wire logic       ss_suspend_status_en,
  input  wire logic       ss_connect_status_en,
  input  wire logic       ss_suspended,
  input  wire logic       ss_connected,
  input  wire logic [3:0] port_power_req,
  input  wire logic       scl_i,
  output logic            scl_o,
  output logic            scl_oe,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic       eeprom_scl_drive,
  input  wire logic       serial_sda_drive_low,
  output logic            host_scl,
  output logic            serial_sda_in,
  output logic [hscap_pkg::NUM_PORTS-1:0] port_power_switch_ctl,
  output logic            port4_overcurrent_event,
  output logic            i2c_mode,
  output logic            power_switching_enabled,
  output logic            ganged_mode,
  output logic            slave_addr_bit1_strap,
  output logic            straps_valid
);
  import hscap_pkg::*;

  // Applies the captured polarity to an active-high power request.
  function automatic logic [NUM_PORTS-1:0] apply_pol(input logic [NUM_PORTS-1:0] req,
                                                     input logic act_high);
    apply_pol = act_high ? req : ~req;
  endfunction

  // Two-flop synchronisers for all pin inputs; stage one feeds stage two only.
  // Stages reset to the idle-high pin level, so no false over-current follows reset.
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  logic [6:0] pins;
  assign pins = {sda_i, scl_i, port4_overcurrent_n, ganged_strap, switch_polarity_strap,
                 power_mgmt_disable_strap_i, serial_mode_select_strap_i};

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sync1_q <= PIN_SYNC_RST;
      sync2_q <= PIN_SYNC_RST;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
    end
  end

  logic s_mode;
  logic s_pwr;
  logic s_pol;
  logic s_gang;
  logic s_oc_n;
  logic s_scl;
  logic s_sda;
  assign s_mode = sync2_q[0];
  assign s_pwr  = sync2_q[1];
  assign s_pol  = sync2_q[2];
  assign s_gang = sync2_q[3];
  assign s_oc_n = sync2_q[4];
  assign s_scl  = sync2_q[5];
  assign s_sda  = sync2_q[6];

  // The capture waits for the synchronisers to fill after reset release,
  // so straps are sampled from settled pins rather than reset constants.
  hscap_state_t state_q;
  hscap_state_t state_d;
  logic [1:0]   wait_q;
  logic [1:0]   wait_d;
  logic         mode_q, mode_d;
  logic         pwr_dis_q, pwr_dis_d;
  logic         pol_q, pol_d;
  logic         gang_q, gang_d;

  always_comb begin
    state_d   = state_q;
    wait_d    = wait_q;
    mode_d    = mode_q;
    pwr_dis_d = pwr_dis_q;
    pol_d     = pol_q;
    gang_d    = gang_q;
    unique case (state_q)
      HSCAP_RESET: begin
        wait_d = wait_q + 2'h1;
        if (wait_q == CAPTURE_WAIT) begin
          state_d = HSCAP_CAPTURE;
        end
      end
      HSCAP_CAPTURE: begin
        mode_d    = s_mode;
        pwr_dis_d = s_pwr;
        pol_d     = s_pol;
        gang_d    = s_gang;
        state_d   = HSCAP_RUN;
      end
      HSCAP_RUN: begin
        state_d = HSCAP_RUN;
      end
      default: begin
        state_d = HSCAP_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_q   <= HSCAP_RESET;
      wait_q    <= 2'h0;
      mode_q    <= SERIAL_MODE_RST;
      pwr_dis_q <= PWR_DISABLE_RST;
      pol_q     <= POLARITY_RST;
      gang_q    <= GANGED_RST;
    end else begin
      state_q   <= state_d;
      wait_q    <= wait_d;
      mode_q    <= mode_d;
      pwr_dis_q <= pwr_dis_d;
      pol_q     <= pol_d;
      gang_q    <= gang_d;
    end
  end

  // Output and pin stage; everything here is registered.
  logic                 run;
  logic                 i2c;
  logic                 sw_on;
  logic [NUM_PORTS-1:0] req_eff;
  assign run   = (state_q == HSCAP_RUN);
  assign i2c   = (mode_q == STRAP_I2C_MODE);
  assign sw_on = (pwr_dis_q == STRAP_PWR_SWITCH_ON);
  // Ganged mode powers all ports from port 1's request; battery charging is only
  // meaningful with switching on, so ports stay off when switching is disabled.
  assign req_eff = !sw_on ? '0 :
                   (gang_q == STRAP_GANGED) ? {NUM_PORTS{port_power_req[0]}} :
                   port_power_req;

  logic                 smode_o_d, smode_oe_d, pmode_o_d, pmode_oe_d;
  logic                 scl_o_d, scl_oe_d, sda_oe_d, oc_d;
  logic [NUM_PORTS-1:0] ctl_d;

  always_comb begin
    smode_oe_d = run && ss_suspend_status_en;
    smode_o_d  = smode_oe_d && ss_suspended;
    pmode_oe_d = run && ss_connect_status_en;
    pmode_o_d  = pmode_oe_d && ss_connected;
    scl_oe_d   = run && i2c;
    scl_o_d    = scl_oe_d && eeprom_scl_drive;
    sda_oe_d   = run && serial_sda_drive_low;
    oc_d       = run && sw_on && !s_oc_n;
    ctl_d      = apply_pol(run ? req_eff : '0, pol_q == STRAP_POL_ACTIVE_HIGH);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      serial_mode_select_strap_o  <= 1'h0;
      serial_mode_select_strap_oe <= 1'h0;
      power_mgmt_disable_strap_o  <= 1'h0;
      power_mgmt_disable_strap_oe <= 1'h0;
      scl_o                       <= 1'h0;
      scl_oe                      <= 1'h0;
      sda_o                       <= 1'h0;
      sda_oe                      <= 1'h0;
      host_scl                    <= 1'h1;
      serial_sda_in               <= 1'h1;
      port_power_switch_ctl       <= '0;
      port4_overcurrent_event     <= 1'h0;
      i2c_mode                    <= SERIAL_MODE_RST;
      power_switching_enabled     <= 1'h0;
      ganged_mode                 <= 1'h0;
      slave_addr_bit1_strap       <= 1'h0;
      straps_valid                <= 1'h0;
    end else begin
      serial_mode_select_strap_o  <= smode_o_d;
      serial_mode_select_strap_oe <= smode_oe_d;
      power_mgmt_disable_strap_o  <= pmode_o_d;
      power_mgmt_disable_strap_oe <= pmode_oe_d;
      scl_o                       <= scl_o_d;
      scl_oe                      <= scl_oe_d;
      sda_o                       <= 1'h0;
      sda_oe                      <= sda_oe_d;
      host_scl                    <= i2c ? 1'h1 : s_scl;
      serial_sda_in               <= s_sda;
      port_power_switch_ctl       <= ctl_d;
      port4_overcurrent_event     <= oc_d;
      i2c_mode                    <= mode_q;
      power_switching_enabled     <= run && sw_on;
      ganged_mode                 <= run && sw_on && gang_q;
      slave_addr_bit1_strap       <= !i2c && pwr_dis_q;
      straps_valid                <= run;
    end
  end
endmodule

// *** src/hscap_pkg.sv ***
// Package with strap reset values and field positions for the strap capture block.
package hscap_pkg;
  localparam int unsigned NUM_PORTS = 4;
  localparam logic STRAP_I2C_MODE = 1'h1;
  localparam logic STRAP_PWR_SWITCH_ON = 1'h0;
  localparam logic STRAP_POL_ACTIVE_HIGH = 1'h1;
  localparam logic STRAP_GANGED = 1'h1;
  localparam logic SERIAL_MODE_RST = 1'h1;
  localparam logic PWR_DISABLE_RST = 1'h0;
  localparam logic POLARITY_RST = 1'h1;
  localparam logic GANGED_RST = 1'h0;
  localparam logic [6:0] PIN_SYNC_RST = 7'h7F;
  localparam logic [1:0] CAPTURE_WAIT = 2'h2;
  localparam int unsigned SLAVE_ADDR_BIT1_POS = 1;
  localparam int unsigned PORT4_IDX = 3;
  typedef enum logic [2:0] {
    HSCAP_RESET   = 3'h1,
    HSCAP_CAPTURE = 3'h2,
    HSCAP_RUN     = 3'h4
  } hscap_state_t;
endpackage

// *** dv/hscap_top_assertions.sv ***
// Concurrent checks on strap capture, status pins and power control.
`timescale 1ns/1ps
module hscap_top_assertions (
  input wire logic       clk_sys,
  input wire logic       rstn,
  input wire logic       port4_overcurrent_n,
  input wire logic       port4_overcurrent_event,
  input wire logic       power_switching_enabled,
  input wire logic       straps_valid,
  input wire logic       i2c_mode,
  input wire logic       ganged_mode,
  input wire logic       scl_oe,
  input wire logic       slave_addr_bit1_strap,
  input wire logic       serial_mode_select_strap_o,
  input wire logic       serial_mode_select_strap_oe,
  input wire logic       power_mgmt_disable_strap_oe,
  input wire logic       ss_suspend_status_en,
  input wire logic       ss_suspended,
  input wire logic [3:0] port_power_req,
  input wire logic [3:0] port_power_switch_ctl
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  chk_valid_hold: assert property (
    straps_valid |=> straps_valid && $stable(i2c_mode) && $stable(power_switching_enabled)
      && $stable(slave_addr_bit1_strap)) else $error("strap value moved after capture");
  chk_oc_event: assert property (
    (!port4_overcurrent_n) [*4] ##0 (straps_valid && power_switching_enabled)
      |-> port4_overcurrent_event) else $error("over-current low level not reported");
  chk_oc_masked: assert property (
    straps_valid && !power_switching_enabled |-> !port4_overcurrent_event)
    else $error("over-current reported with switching off");
  chk_ctl_pol: assert property (
    straps_valid && $past(straps_valid) && power_switching_enabled && !ganged_mode
      |-> (port_power_switch_ctl ^ $past(port_power_req)) inside {4'h0, 4'hF})
    else $error("power controls do not follow requests");
  chk_ganged_ctl: assert property (
    straps_valid && ganged_mode && power_switching_enabled
      |-> port_power_switch_ctl inside {4'h0, 4'hF}) else $error("ganged controls differ");
  chk_scl_smbus: assert property (
    straps_valid && !i2c_mode |-> !scl_oe) else $error("clock driven in host mode");
  chk_addr_bit1: assert property (
    straps_valid |-> slave_addr_bit1_strap == (!i2c_mode && !power_switching_enabled))
    else $error("address bit 1 wrong");
  chk_strap_quiet: assert property (
    !straps_valid |-> !serial_mode_select_strap_oe && !power_mgmt_disable_strap_oe)
    else $error("strap pin driven before capture");
  chk_suspend_pin: assert property (
    straps_valid && $past(straps_valid) && $past(ss_suspend_status_en)
      |-> serial_mode_select_strap_oe && serial_mode_select_strap_o == $past(ss_suspended))
    else $error("suspend status not driven");
  cover property (straps_valid && !i2c_mode);
  cover property (port4_overcurrent_event);
  cover property (straps_valid && ganged_mode);
endmodule
bind hscap_top hscap_top_assertions i_chk (.clk_sys(clk_sys), .rstn(rstn),
  .port4_overcurrent_n(port4_overcurrent_n), .port4_overcurrent_event(port4_overcurrent_event),
  .power_switching_enabled(power_switching_enabled), .straps_valid(straps_valid),
  .i2c_mode(i2c_mode), .ganged_mode(ganged_mode), .scl_oe(scl_oe),
  .slave_addr_bit1_strap(slave_addr_bit1_strap),
  .serial_mode_select_strap_o(serial_mode_select_strap_o),
  .serial_mode_select_strap_oe(serial_mode_select_strap_oe),
  .power_mgmt_disable_strap_oe(power_mgmt_disable_strap_oe),
  .ss_suspend_status_en(ss_suspend_status_en), .ss_suspended(ss_suspended),
  .port_power_req(port_power_req), .port_power_switch_ctl(port_power_switch_ctl));

// *** dv/hscap_switch_model.sv ***
// Downstream power switch model with the port 4 fault flag.
`timescale 1ns/1ps
module hscap_switch_model (
  input  wire logic [3:0] ctl,
  input  wire logic       act_high,
  input  wire logic       fault,
  output logic      [3:0] port_on,
  output logic            oc_n
);
  assign port_on = act_high ? ctl : ~ctl;
  // The fault flag is open drain with a pull-up, so it idles high.
  assign oc_n = !fault;
endmodule

// *** dv/tb.sv ***
// Self-checking bench for strap capture, status pins and power control.
`timescale 1ns/1ps
module tb;
  logic       clk_sys = 1'h0, rstn = 1'h0, sm = 1'h1, pm = 1'h0, pol = 1'h1, gang = 1'h0;
  logic       pol_b = 1'h1, fault = 1'h0, sus_en = 1'h0, con_en = 1'h0, ser = 1'h0;
  logic       sm_o, sm_oe, pm_o, pm_oe, scl_o, scl_oe, sda_oe, oc_n, ev, i2c, pse, gm, a1, vld;
  logic       sda_o, hscl, sdin, sus = 1'h0, con = 1'h0;
  logic [3:0] req = 4'h0, on, ctl, c;
  logic [3:0] tbl [5] = '{4'h8, 4'h3, 4'h6, 4'hA, 4'h4};
  int         n_mismatch = 0;
  int         num_checks = 0;
  wire        sm_pin = sm_oe ? sm_o : sm;
  wire        pm_pin = pm_oe ? pm_o : pm;
  // The host drives the clock pin from ser; the data pin has a pull-up.
  wire        scl_pin = scl_oe ? scl_o : ser;
  wire        sda_pin = sda_oe ? sda_o : 1'h1;
  initial forever #10 clk_sys = ~clk_sys;
  hscap_top i_dut (.clk_sys(clk_sys), .rstn(rstn), .serial_mode_select_strap_i(sm_pin),
    .serial_mode_select_strap_o(sm_o), .serial_mode_select_strap_oe(sm_oe),
    .power_mgmt_disable_strap_i(pm_pin), .power_mgmt_disable_strap_o(pm_o),
    .power_mgmt_disable_strap_oe(pm_oe), .switch_polarity_strap(pol), .ganged_strap(gang),
    .port4_overcurrent_n(oc_n), .ss_suspend_status_en(sus_en), .ss_connect_status_en(con_en),
    .ss_suspended(sus), .ss_connected(con), .port_power_req(req),
    .scl_i(scl_pin), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_pin), .sda_o(sda_o),
    .sda_oe(sda_oe), .eeprom_scl_drive(ser), .serial_sda_drive_low(ser), .host_scl(hscl),
    .serial_sda_in(sdin), .port_power_switch_ctl(ctl), .port4_overcurrent_event(ev),
    .i2c_mode(i2c), .power_switching_enabled(pse), .ganged_mode(gm),
    .slave_addr_bit1_strap(a1), .straps_valid(vld));
  hscap_switch_model i_sw (.ctl(ctl), .act_high(pol_b), .fault(fault), .port_on(on),
    .oc_n(oc_n));
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Outputs are sampled on the falling edge so the register updates have settled.
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic boot(input logic [3:0] s);
    @(posedge clk_sys);
    {sm, pm, pol, gang} <= s;
    pol_b <= s[1];
    rstn <= 1'h0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'h1;
    wt(4);
    chk(vld, 1'h0);
    wt(1);
    chk(vld, 1'h1);
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #20000;
    n_mismatch++;
    summarize();
  end
  initial begin
    for (int k = 0; k < 5; k++) begin
      c = tbl[k];
      boot(c);
      chk(i2c, c[3]);
      chk(pse, !c[2]);
      chk(a1, !c[3] && c[2]);
      chk({sm_oe, pm_oe}, 4'h0);
      if (!c[2]) chk(gm, c[0]);
      // Flipping the strap pins after capture must not disturb the latched modes.
      @(posedge clk_sys);
      {sm, pm, pol, gang} <= ~c;
      {ser, req} <= 5'h15;
      wt(4);
      chk({i2c, pse, a1}, {c[3], !c[2], !c[3] && c[2]});
      chk({scl_oe, scl_o}, {2{c[3]}});
      chk({sda_oe, sda_o, sdin, hscl}, 4'h9);
      chk(on, c[2] ? 4'h0 : (c[0] ? 4'hF : 4'h5));
      @(posedge clk_sys);
      {fault, sus_en, con_en, sus, con} <= {3'h7, c[0], c[1]};
      wt(5);
      chk(ev, !c[2]);
      chk({sm_pin, sm_oe, pm_pin, pm_oe}, {c[0], 1'h1, c[1], 1'h1});
      @(posedge clk_sys);
      {fault, sus_en, con_en, sus, con, ser, req} <= 10'h0;
      wt(5);
      chk({ev, sm_oe, pm_oe}, 4'h0);
      chk({sda_oe, sdin, hscl}, {2'h1, c[3]});
    end
    summarize();
  end
endmodule
